// File: hdl/liu_device.sv
// device end: interrupt flags, masks, request pin and reset control
// Functional notes
// - config 00 or 11 gives open-drain low pin
// - config 01 gives push-pull active-low pin
// - config 10 gives push-pull active-high pin
// - one pin, asserted exactly while unmasked flag pending
// - events latch into flag registers 19h, 1ah
// - per-source enable via mask registers 14h, 15h
// - mask zero passes flag, one blocks it
// - level events set flags through edge selection
// - reading a flag register releases the pin
// - read clears returned flags, new events relatch
// - sixteen source categories feed the flags
// - eight level events with status and edge bits
// - eight pulse events with flag and mask only
// - write to 01h resets device within 1 us
// - host holds reset pin low 100 ns minimum
// - reference clock keeps running during hardware reset
// - host waits 50 us after any reset
// - host sets line standard bit after reset
// - reset floats drivers, clears state, loads defaults
// - soft reset keeps the line standard bit
`timescale 1ns/100ps
`default_nettype none
module liu_device
   import liu_pkg::*;
(
   input  wire logic       clk,           // master reference clock
   input  wire logic       sys_rst,       // power-on reset, async high
   liu_link_if.dev         link,          // pins toward the host
   input  wire logic [7:0] levelStatus,   // live level status, status 0 layout
   input  wire logic [7:0] pulseEvents,   // one-cycle events, flags 1 layout
   input  wire logic [5:0] auxStatus,     // low bits of line status 1
   output logic            lineStandard,  // line standard select, 1 = T1/J1
   output logic            driverOe,      // line drivers enabled
   output logic            inReset        // internal reset in progress
);

   typedef struct packed {
      logic [1:0] pinCfg;
      logic       lineStd;
      logic [7:0] mask0;
      logic [7:0] mask1;
      logic [7:0] edgeSel;
      logic [7:0] flags0;
      logic [7:0] flags1;
      logic [7:0] statPrev;
      logic [7:0] rdData;
      logic       drvEn;
      logic [5:0] softCnt;
      logic       intOut;
      logic       intOe;
   } liu_dev_state_t;

   localparam liu_dev_state_t DEV_RST = '{
      pinCfg:   CFG_PIN_RST,
      lineStd:  LINE_STD_RST,
      mask0:    MASK_RST,
      mask1:    MASK_RST,
      edgeSel:  EDGE_SEL_RST,
      flags0:   FLAGS_RST,
      flags1:   FLAGS_RST,
      statPrev: 8'h00,
      rdData:   8'h00,
      drvEn:    DRV_EN_RST,
      softCnt:  6'h00,
      intOut:   1'b0,
      intOe:    1'b0
   };

   liu_dev_state_t s;
   liu_dev_state_t n;
   logic           rstNSync;
   logic [7:0]     setLevel;
   logic           pending;
   logic           softActive;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction

   // edge bit zero takes rising changes only, one takes any change
   function automatic logic [7:0] level_set
   (
      input logic [7:0] now,
      input logic [7:0] prev,
      input logic [7:0] anyEdge
   );
      level_set = (now & ~prev) | (anyEdge & ~now & prev);
   endfunction

   assign softActive = (s.softCnt != 6'h00);

   // hardware reset pin comes from outside the clock domain
   liu_sync2 u_rst_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (link.rstN),
      .dout    (rstNSync)
   );

   always_comb
   begin
      n = s;
      n.rdData = 8'h00;
      setLevel = level_set(levelStatus, s.statPrev, s.edgeSel);
      n.statPrev = levelStatus;

      if (!rstNSync)
      begin
         n = DEV_RST;
      end
      else if (softActive)
      begin
         n = DEV_RST;
         n.lineStd = s.lineStd;
         n.softCnt = s.softCnt - 6'h01;
      end
      else
      begin
         n.flags0 = s.flags0 | setLevel;
         n.flags1 = s.flags1 | pulseEvents;

         if (link.rd)
         begin
            case (link.addr)
               OFF_GLOBAL_CFG:   n.rdData = {5'h00, s.lineStd, s.pinCfg};
               OFF_MASK0:        n.rdData = s.mask0;
               OFF_MASK1:        n.rdData = s.mask1;
               OFF_EDGE_SEL:     n.rdData = s.edgeSel;
               OFF_LINE_STATUS0: n.rdData = levelStatus;
               OFF_LINE_STATUS1: n.rdData = {2'h0, auxStatus};
               OFF_FLAGS0:       n.rdData = s.flags0;
               OFF_FLAGS1:       n.rdData = s.flags1;
               OFF_DRV_CTL:      n.rdData = {7'h00, s.drvEn};
               default:          n.rdData = 8'h00;
            endcase
            // only the returned bits clear; a same-cycle event stays set
            if (hit(link.addr, OFF_FLAGS0))
               n.flags0 = setLevel;
            if (hit(link.addr, OFF_FLAGS1))
               n.flags1 = pulseEvents;
         end

         if (link.wr)
         begin
            if (hit(link.addr, OFF_SOFT_RST))
               n.softCnt = SOFT_RST_CYC;
            if (hit(link.addr, OFF_GLOBAL_CFG))
            begin
               n.pinCfg  = link.wdata[CFG_PIN_LSB +: 2];
               n.lineStd = link.wdata[CFG_STD_BIT];
            end
            if (hit(link.addr, OFF_MASK0))
               n.mask0 = link.wdata;
            if (hit(link.addr, OFF_MASK1))
               n.mask1 = link.wdata;
            if (hit(link.addr, OFF_EDGE_SEL))
               n.edgeSel = link.wdata;
            if (hit(link.addr, OFF_DRV_CTL))
               n.drvEn = link.wdata[0];
         end
      end

      pending = (|(n.flags0 & ~n.mask0)) | (|(n.flags1 & ~n.mask1));

      case (n.pinCfg)
         PIN_PP_LOW:
         begin
            n.intOut = ~pending;
            n.intOe  = 1'b1;
         end
         PIN_PP_HIGH:
         begin
            n.intOut = pending;
            n.intOe  = 1'b1;
         end
         default:
         begin
            // pull low only; the external pull-up gives the idle level
            n.intOut = 1'b0;
            n.intOe  = pending;
         end
      endcase

      // pin floats while any reset is in progress
      if (!rstNSync || softActive)
      begin
         n.intOut = 1'b0;
         n.intOe  = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         s <= DEV_RST;
      else
         s <= n;
   end

   assign link.rdata   = s.rdData;
   assign link.intOut  = s.intOut;
   assign link.intOe   = s.intOe;
   assign lineStandard = s.lineStd;
   assign driverOe     = s.drvEn;
   assign inReset      = ~rstNSync | softActive;

endmodule
`default_nettype wire

// File: hdl/liu_pkg.sv
// shared constants of the line interface interrupt and reset logic
package liu_pkg;

   // register bus geometry
   localparam int ADDR_W = 5;

   // register offsets
   localparam logic [4:0] OFF_SOFT_RST     = 5'h01;
   localparam logic [4:0] OFF_GLOBAL_CFG   = 5'h02;
   localparam logic [4:0] OFF_MASK0        = 5'h14;
   localparam logic [4:0] OFF_MASK1        = 5'h15;
   localparam logic [4:0] OFF_EDGE_SEL     = 5'h16;
   localparam logic [4:0] OFF_LINE_STATUS0 = 5'h17;
   localparam logic [4:0] OFF_LINE_STATUS1 = 5'h18;
   localparam logic [4:0] OFF_FLAGS0       = 5'h19;
   localparam logic [4:0] OFF_FLAGS1       = 5'h1a;
   localparam logic [4:0] OFF_DRV_CTL      = 5'h1f;

   // global configuration field layout
   localparam int CFG_PIN_LSB = 0;
   localparam int CFG_STD_BIT = 2;

   // request pin drive modes
   localparam logic [1:0] PIN_OPEN_DRAIN = 2'h0;
   localparam logic [1:0] PIN_PP_LOW     = 2'h1;
   localparam logic [1:0] PIN_PP_HIGH    = 2'h2;

   // values after reset
   localparam logic [1:0] CFG_PIN_RST    = 2'h0;
   localparam logic       LINE_STD_RST   = 1'b0;
   localparam logic [7:0] MASK_RST       = 8'hff;
   localparam logic [7:0] EDGE_SEL_RST   = 8'h00;
   localparam logic [7:0] FLAGS_RST      = 8'h00;
   localparam logic       DRV_EN_RST     = 1'b0;

   // timing
   localparam int CLK_PERIOD_NS   = 25;
   localparam int SOFT_RST_MAX_NS = 1000;
   localparam int HW_RST_MIN_NS   = 100;
   localparam int SETTLE_MIN_NS   = 50000;

   localparam logic [5:0]  SOFT_RST_CYC = 6'(SOFT_RST_MAX_NS / CLK_PERIOD_NS);
   localparam logic [10:0] HW_RST_CYC   = 11'((HW_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] SETTLE_CYC   = 11'((SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// File: hdl/liu_link_if.sv
// register bus, reset pin and interrupt request pin between host and device
`timescale 1ns/100ps
`default_nettype none
interface liu_link_if;
   logic [4:0] addr;      // register offset
   logic [7:0] wdata;     // write data
   logic       wr;        // write strobe
   logic       rd;        // read strobe
   logic [7:0] rdata;     // read data, cycle after rd
   logic       rstN;      // hardware reset pin, low active
   logic       intOut;    // request pin driven value
   logic       intOe;     // request pin output enable
   logic       intLevel;  // resolved pin level

   // external pull-up holds the pin high while nobody drives
   assign intLevel = intOe ? intOut : 1'b1;

   modport dev
   (
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      input  rstN,
      output rdata,
      output intOut,
      output intOe
   );

   modport host
   (
      output addr,
      output wdata,
      output wr,
      output rd,
      output rstN,
      input  rdata,
      input  intLevel
   );
endinterface
`default_nettype wire

// File: hdl/liu_sync2.sv
// two flip-flop synchroniser for a level from another domain
`timescale 1ns/100ps
`default_nettype none
module liu_sync2
(
   input  wire logic clk,      // clock
   input  wire logic sys_rst,  // async reset, high
   input  wire logic din,      // asynchronous level
   output logic      dout      // synchronised level
);
   typedef struct packed {
      logic meta;
      logic stable;
   } liu_sync_state_t;

   liu_sync_state_t s;
   liu_sync_state_t n;

   always_comb
   begin
      n.meta   = din;
      n.stable = s.meta;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         s <= '0;
      else
         s <= n;
   end

   assign dout = s.stable;
endmodule
`default_nettype wire

// File: hdl/liu_host.sv
// host end: reset sequencing, settle wait, configuration and bus access
`timescale 1ns/100ps
`default_nettype none
module liu_host
   import liu_pkg::*;
(
   input  wire logic       clk,         // system clock, same as device clock
   input  wire logic       sys_rst,     // async reset, high
   liu_link_if.host        link,        // pins toward the device
   input  wire logic [4:0] usrAddr,     // register offset
   input  wire logic [7:0] usrWdata,    // write data
   input  wire logic       usrWr,       // write strobe
   input  wire logic       usrRd,       // read strobe
   output logic [7:0]      usrRdata,    // read data, cycle after usrRd
   input  wire logic       hwResetReq,  // pulse: apply hardware reset
   input  wire logic       cfgT1,       // line standard wanted, 1 = T1/J1
   input  wire logic [1:0] cfgPin,      // request pin mode to program
   output logic            busy,        // accesses ignored while high
   output logic            irqActive    // request pin shows asserted level
);

   typedef enum logic [1:0] {
      HS_RESET  = 2'b00,
      HS_SETTLE = 2'b01,
      HS_CONFIG = 2'b10,
      HS_READY  = 2'b11
   } liu_host_phase_t;

   typedef struct packed {
      liu_host_phase_t phase;
      logic [10:0]     cnt;
      logic            rstN;
   } liu_host_state_t;

   localparam liu_host_state_t HOST_RST = '{phase: HS_RESET, cnt: 11'h000, rstN: 1'b0};

   liu_host_state_t s;
   liu_host_state_t n;
   logic            ready;
   logic            intLevelSync;

   assign ready = (s.phase == HS_READY);

   liu_sync2 u_irq_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (link.intLevel),
      .dout    (intLevelSync)
   );

   always_comb
   begin
      n = s;
      n.cnt = 11'(s.cnt + 11'h001);
      unique case (s.phase)
         HS_RESET:
         begin
            if (s.cnt == HW_RST_CYC - 11'h001)
            begin
               n.phase = HS_SETTLE;
               n.cnt   = 11'h000;
               n.rstN  = 1'b1;
            end
         end
         HS_SETTLE:
         begin
            if (s.cnt == SETTLE_CYC - 11'h001)
               n.phase = HS_CONFIG;
         end
         HS_CONFIG:
         begin
            n.phase = HS_READY;
            n.cnt   = 11'h000;
         end
         HS_READY:
         begin
            n.cnt = 11'h000;
            if (usrWr && usrAddr == OFF_SOFT_RST)
               n.phase = HS_SETTLE;
         end
      endcase
      // clock keeps running through the reset
      if (hwResetReq)
         n = HOST_RST;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         s <= HOST_RST;
      else
         s <= n;
   end

   // configuration write after settle, otherwise user accesses pass through
   assign link.addr  = (s.phase == HS_CONFIG) ? OFF_GLOBAL_CFG : usrAddr;
   assign link.wdata = (s.phase == HS_CONFIG) ? {5'h00, cfgT1, cfgPin} : usrWdata;
   assign link.wr    = (s.phase == HS_CONFIG) | (usrWr & ready);
   assign link.rd    = usrRd & ready;
   assign link.rstN  = s.rstN;
   assign usrRdata   = link.rdata;
   assign busy       = ~ready;
   assign irqActive  = ready & ((cfgPin == PIN_PP_HIGH) ? intLevelSync : ~intLevelSync);

endmodule
`default_nettype wire

// File: verif/liu_props.sv
// assertions on the link between host end and device end
`timescale 1ns/100ps
`default_nettype none
module liu_props
   import liu_pkg::*;
(
   input  wire logic       clk,      // clock
   input  wire logic       sys_rst,  // async reset, high
   input  wire logic [4:0] addr,     // register offset
   input  wire logic [7:0] wdata,    // write data
   input  wire logic       wr,       // write strobe
   input  wire logic       rd,       // read strobe
   input  wire logic [7:0] rdata,    // read data
   input  wire logic       rstN,     // reset pin
   input  wire logic       intOut,   // request pin value
   input  wire logic       intOe     // request pin enable
);
   logic [10:0] settleCnt;
   logic        rstNQ;
   logic [1:0]  pinMode;
   wire logic   softWr = wr && addr == OFF_SOFT_RST;

   // pin mode 3 means unknown, set by any reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         settleCnt <= 11'h0;
         rstNQ     <= 1'b0;
         pinMode   <= 2'h3;
      end
      else
      begin
         rstNQ <= rstN;
         if (!rstN || softWr)
            pinMode <= 2'h3;
         else if (wr && addr == OFF_GLOBAL_CFG)
            pinMode <= wdata[1:0];
         if ((rstN && !rstNQ) || softWr)
            settleCnt <= SETTLE_CYC - 11'h2;
         else if (settleCnt != 11'h0)
            settleCnt <= settleCnt - 11'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_quiet;
      (!intOe && rdata == 8'h00) [*8];
   endsequence

   property p_rdata_idle;
      !$past(rd) |-> rdata == 8'h00;
   endproperty
   property p_open_drain;
      pinMode == 2'h0 && $past(pinMode, 2) == 2'h0 && intOe |-> !intOut;
   endproperty
   property p_pp_low;
      pinMode == 2'h1 && $past(pinMode, 2) == 2'h1 |-> intOe;
   endproperty
   property p_pp_high;
      pinMode == 2'h2 && $past(pinMode, 2) == 2'h2 |-> intOe;
   endproperty
   property p_hw_len;
      $fell(rstN) |-> !rstN [*4];
   endproperty
   property p_settle;
      (wr || rd) |-> settleCnt == 11'h0;
   endproperty
   property p_soft_quiet;
      softWr |-> ##2 s_quiet;
   endproperty
   property p_hw_quiet;
      $fell(rstN) |-> ##4 s_quiet;
   endproperty

   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside its slot");
   a_open_drain: assert property (p_open_drain)
      else $error("open drain pin driven high");
   a_pp_low: assert property (p_pp_low)
      else $error("push-pull low pin not driven");
   a_pp_high: assert property (p_pp_high)
      else $error("push-pull high pin not driven");
   a_hw_len: assert property (p_hw_len)
      else $error("reset pin pulse too short");
   a_settle: assert property (p_settle)
      else $error("access during settle time");
   a_soft_quiet: assert property (p_soft_quiet)
      else $error("device active during soft reset");
   a_hw_quiet: assert property (p_hw_quiet)
      else $error("device active during hardware reset");
endmodule
`default_nettype wire

// File: verif/liu_interrupt_and_reset_tb.sv
// testbench joining host end and device end
`timescale 1ns/100ps
`default_nettype none
module liu_interrupt_and_reset_tb
   import liu_pkg::*;
;
   logic       clk = 1'b0, sys_rst = 1'b1, usrWr = 1'b0, usrRd = 1'b0;
   logic       hwResetReq = 1'b0, cfgT1 = 1'b1;
   logic       busy, irqActive, lineStandard, driverOe, inReset;
   logic [1:0] cfgPin = 2'h0;
   logic [4:0] usrAddr = 5'h00;
   logic [5:0] auxStatus = 6'h2a;
   logic [7:0] usrWdata = 8'h00, levelStatus = 8'h00, pulseEvents = 8'h00, usrRdata;
   int         error_cnt = 0, n_compared = 0;
   logic [4:0] regAddr [9] = '{OFF_MASK0, OFF_MASK1, OFF_EDGE_SEL, OFF_FLAGS0, OFF_FLAGS1,
                              OFF_GLOBAL_CFG, 5'h03, OFF_LINE_STATUS0, OFF_LINE_STATUS1};
   logic [7:0] regExp [9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h2a};

   liu_link_if lk ();
   liu_device i_liu_device (.clk(clk), .sys_rst(sys_rst), .link(lk.dev),
      .levelStatus(levelStatus), .pulseEvents(pulseEvents), .auxStatus(auxStatus),
      .lineStandard(lineStandard), .driverOe(driverOe), .inReset(inReset));
   liu_host i_liu_host (.clk(clk), .sys_rst(sys_rst), .link(lk.host), .usrAddr(usrAddr),
      .usrWdata(usrWdata), .usrWr(usrWr), .usrRd(usrRd), .usrRdata(usrRdata),
      .hwResetReq(hwResetReq), .cfgT1(cfgT1), .cfgPin(cfgPin), .busy(busy),
      .irqActive(irqActive));
   liu_props i_liu_props (.clk(clk), .sys_rst(sys_rst), .addr(lk.addr), .wdata(lk.wdata),
      .wr(lk.wr), .rd(lk.rd), .rdata(lk.rdata), .rstN(lk.rstN), .intOut(lk.intOut),
      .intOe(lk.intOe));

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wreg(input logic [4:0] a, input logic [7:0] v);
      usrAddr  <= a;
      usrWdata <= v;
      usrWr    <= 1'b1;
      tick(1);
      usrWr <= 1'b0;
      tick(1);
   endtask

   task automatic rreg(input logic [4:0] a, input logic [7:0] e);
      usrAddr <= a;
      usrRd   <= 1'b1;
      tick(1);
      usrRd <= 1'b0;
      #1 chk(usrRdata, e);
      tick(1);
   endtask

   task automatic wait_ready();
      int k = 0;
      while (busy !== 1'b0 && k < 5000)
      begin
         tick(1);
         k++;
      end
      if (k == 5000)
      begin
         error_cnt++;
         end_of_test();
      end
   endtask

   initial
   begin
      tick(20);
      sys_rst <= 1'b0;
      tick(1);
      wait_ready();
      wreg(OFF_LINE_STATUS1, 8'hff);
      foreach (regAddr[k]) rreg(regAddr[k], regExp[k]);
      chk(8'({lineStandard, driverOe}), 8'h02);
      // pulse events, all masked, then bit 3 unmasked
      for (int i = 0; i < 8; i++)
      begin
         pulseEvents <= 8'h01 << i;
         tick(1);
         pulseEvents <= 8'h00;
         tick(1);
         chk(8'(lk.intLevel), 8'h01);
         rreg(OFF_FLAGS1, 8'h01 << i);
         rreg(OFF_FLAGS1, 8'h00);
      end
      wreg(OFF_MASK1, 8'hf7);
      pulseEvents <= 8'h28;
      tick(1);
      pulseEvents <= 8'h00;
      tick(4);
      chk(8'({lk.intLevel, irqActive}), 8'h01);
      rreg(OFF_FLAGS1, 8'h28);
      tick(1);
      chk(8'(lk.intLevel), 8'h01);
      // level events and edge selection
      wreg(OFF_MASK0, 8'h00);
      levelStatus <= 8'hff;
      tick(2);
      rreg(OFF_LINE_STATUS0, 8'hff);
      rreg(OFF_FLAGS0, 8'hff);
      levelStatus <= 8'h00;
      tick(2);
      rreg(OFF_FLAGS0, 8'h00);
      wreg(OFF_EDGE_SEL, 8'h0f);
      levelStatus <= 8'hff;
      tick(2);
      rreg(OFF_FLAGS0, 8'hff);
      levelStatus <= 8'h00;
      tick(2);
      rreg(OFF_FLAGS0, 8'h0f);
      // each pin drive mode
      for (int m = 0; m < 4; m++)
      begin
         cfgPin <= 2'(m);
         wreg(OFF_GLOBAL_CFG, 8'(m + 4));
         tick(4);
         chk(8'(lk.intLevel), 8'(m != 2));
         levelStatus[0] <= ~levelStatus[0];
         tick(4);
         chk(8'({lk.intLevel, irqActive}), 8'(m == 2 ? 3 : 1));
         rreg(OFF_FLAGS0, 8'h01);
         tick(1);
         chk(8'(lk.intLevel), 8'(m != 2));
      end
      // hardware reset
      wreg(OFF_DRV_CTL, 8'h01);
      hwResetReq <= 1'b1;
      tick(1);
      hwResetReq <= 1'b0;
      tick(3);
      chk(8'(lk.rstN), 8'h00);
      tick(2);
      chk(8'({inReset, lineStandard, driverOe}), 8'h04);
      wait_ready();
      rreg(OFF_MASK0, 8'hff);
      // soft reset keeps line standard
      cfgT1 <= 1'b0;
      wreg(OFF_DRV_CTL, 8'h01);
      wreg(OFF_SOFT_RST, 8'h00);
      chk(8'(inReset), 8'h01);
      tick(42);
      chk(8'({inReset, lineStandard, driverOe}), 8'h02);
      wait_ready();
      rreg(OFF_MASK0, 8'hff);
      chk(8'(lineStandard), 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
